// [ufd_top.sv]
// FIFO and data port of the serial transceiver with its AXI4-Lite slave.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module ufd_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ufd_pkg::AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ufd_pkg::AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire ufd_pkg::ufd_rx_entry_t rx_entry,
  output logic rx_ready,
  output logic rx_fifo_req,
  output logic tx_fifo_req,
  output logic rx_timeout_irq_enable
);
  import ufd_pkg::*;

  // ****************************************************************
  // Register state
  // ****************************************************************

  // FIFO control word; steers queue mode, flushes and trigger levels.
  ufd_fifo_ctrl_t fifo_control_ff;
  // Line control word; only the time-out enable bit is kept.
  logic [7:0] line_control_ff;
  // Transmit queue, entry 0 is the head handed to the line.
  logic [7:0] tx_mem_ff [DEPTH];
  logic [7:0] nxt_tx_mem [DEPTH];
  logic [CW-1:0] tx_cnt_ff;
  logic [CW-1:0] nxt_tx_cnt;
  // Receive queue, entry 0 is the oldest byte.
  ufd_rx_entry_t rx_mem_ff [DEPTH];
  ufd_rx_entry_t nxt_rx_mem [DEPTH];
  logic [CW-1:0] rx_cnt_ff;
  logic [CW-1:0] nxt_rx_cnt;
  // Registered outputs.
  logic tx_valid_ff;
  logic rx_ready_ff;
  logic rx_fifo_req_ff;
  logic tx_fifo_req_ff;
  logic rx_to_en_ff;

  // ****************************************************************
  // Write channel state
  // ****************************************************************

  // Address and data are each parked until both have arrived.
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic wlane0_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;

  // Read channel state.
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // ****************************************************************
  // Handshake and address decode
  // ****************************************************************

  // Channel transfers of this cycle.
  wire aw_take = awvalid & awready_ff;
  wire w_take = wvalid & wready_ff;
  wire ar_take = arvalid & arready_ff;
  // A write is carried out in the cycle in which both halves are parked.
  wire wr_do = aw_hold_ff & w_hold_ff;
  wire wr_en = wr_do & wlane0_ff;
  wire fifo_on = fifo_control_ff.fifo_mode_select;

  // Write address decode against byte addresses.
  wire w_ctl = awaddr_ff == (IDX_FIFO_CONTROL << 2);
  wire w_lctl = awaddr_ff == (IDX_LINE_CONTROL << 2);
  wire w_txb = awaddr_ff == (IDX_TX_BYTE << 2);
  wire w_txh = awaddr_ff == (IDX_TX_HALF << 2);
  wire w_txw = awaddr_ff == (IDX_TX_WORD << 2);
  // Read-only words take writes silently.
  wire w_ro = (awaddr_ff == (IDX_FIFO_STATUS << 2)) | (awaddr_ff == (IDX_LINE_STATUS << 2))
    | (awaddr_ff == (IDX_RX_BYTE << 2)) | (awaddr_ff == (IDX_RX_HALF << 2))
    | (awaddr_ff == (IDX_RX_WORD << 2));
  wire w_hit = w_ctl | w_lctl | w_txb | w_txh | w_txw | w_ro;

  // Read address decode.
  wire r_ctl = araddr == (IDX_FIFO_CONTROL << 2);
  wire r_lctl = araddr == (IDX_LINE_CONTROL << 2);
  wire r_st = araddr == (IDX_FIFO_STATUS << 2);
  wire r_ls = araddr == (IDX_LINE_STATUS << 2);
  wire r_rxb = araddr == (IDX_RX_BYTE << 2);
  wire r_rxh = araddr == (IDX_RX_HALF << 2);
  wire r_rxw = araddr == (IDX_RX_WORD << 2);
  // Write-only data ports read as zero.
  wire r_wo = (araddr == (IDX_TX_BYTE << 2)) | (araddr == (IDX_TX_HALF << 2))
    | (araddr == (IDX_TX_WORD << 2));
  wire r_hit = r_ctl | r_lctl | r_st | r_ls | r_rxb | r_rxh | r_rxw | r_wo;

  // ****************************************************************
  // Transmit queue control
  // ****************************************************************

  // Space limit: eight bytes in FIFO mode, one holding byte otherwise.
  wire [CW-1:0] tx_cap = fifo_on ? CNT_FULL : CNT_ONE;
  // The holding register shares the byte alias address; mode picks the role.
  wire tx_hold_wr = wr_en & w_txb & ~fifo_on;
  // Bytes pushed by an alias write in FIFO mode.
  wire [CW-1:0] tx_push_n = ~(wr_en & fifo_on) ? 4'h0 :
    w_txb ? N_BYTE :
    w_txh ? N_HALF :
    w_txw ? N_WORD : 4'h0;
  wire tx_pop = tx_valid_ff & tx_ready;
  wire [CW-1:0] tx_base = tx_cnt_ff - {3'h0, tx_pop};
  wire [CW-1:0] tx_lvl = TX_TRIG_LVL[fifo_control_ff.tx_trigger_level * 4 +: 4];

  // Shift out the head, then place new bytes lowest lane first.
  always_comb begin
    logic [CW-1:0] slot;
    slot = 4'h0;
    nxt_tx_mem = tx_mem_ff;
    nxt_tx_cnt = tx_base;
    if (tx_pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        nxt_tx_mem[i] = tx_mem_ff[i+1];
      end
    end
    for (int i = 0; i < 4; i++) begin
      slot = tx_base + CW'(i);
      // Bytes beyond the free space are dropped.
      if (CW'(i) < tx_push_n && slot < tx_cap) begin
        nxt_tx_mem[slot[2:0]] = wdata_ff[i*8 +: 8];
        nxt_tx_cnt = slot + 4'h1;
      end
    end
    // A holding write replaces whatever waits, so the empty flag drops.
    if (tx_hold_wr) begin
      nxt_tx_mem[0] = wdata_ff[7:0];
      nxt_tx_cnt = CNT_ONE;
    end
    // A set flush bit keeps the queue empty.
    if (fifo_control_ff.tx_queue_flush) begin
      nxt_tx_cnt = 4'h0;
    end
  end

  // ****************************************************************
  // Receive queue control
  // ****************************************************************

  wire [CW-1:0] rx_cap = fifo_on ? CNT_FULL : CNT_ONE;
  // Bytes requested by a read; the half and word aliases act in FIFO mode.
  wire [CW-1:0] rx_req_n = ~ar_take ? 4'h0 :
    r_rxb ? N_BYTE :
    (r_rxh & fifo_on) ? N_HALF :
    (r_rxw & fifo_on) ? N_WORD : 4'h0;
  // Never remove more than is held.
  wire [CW-1:0] rx_pop_n = (rx_req_n > rx_cnt_ff) ? rx_cnt_ff : rx_req_n;
  wire [CW-1:0] rx_base = rx_cnt_ff - rx_pop_n;
  wire rx_push = rx_valid & rx_ready_ff;
  wire [CW-1:0] rx_lvl = RX_TRIG_LVL[fifo_control_ff.rx_trigger_level * 4 +: 4];

  // Shift out what was read, then append the byte from the line.
  always_comb begin
    logic [CW-1:0] src;
    src = 4'h0;
    nxt_rx_mem = rx_mem_ff;
    nxt_rx_cnt = rx_base;
    for (int i = 0; i < DEPTH; i++) begin
      src = CW'(i) + rx_pop_n;
      if (src < CNT_FULL) begin
        nxt_rx_mem[i] = rx_mem_ff[src[2:0]];
      end
    end
    if (rx_push && rx_base < rx_cap) begin
      nxt_rx_mem[rx_base[2:0]] = rx_entry;
      nxt_rx_cnt = rx_base + 4'h1;
    end
    // A set flush bit discards every entry, arriving ones too.
    if (fifo_control_ff.rx_queue_flush) begin
      nxt_rx_cnt = 4'h0;
    end
  end

  // ****************************************************************
  // Status words
  // ****************************************************************

  // Invalid mark over the entries that are actually held.
  logic rx_err_any;
  always_comb begin
    rx_err_any = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if (CW'(i) < rx_cnt_ff && rx_mem_ff[i].err) begin
        rx_err_any = 1'b1;
      end
    end
  end

  // Counts wrap to zero at eight, so the full flags complete them.
  wire rx_full = rx_cnt_ff == CNT_FULL;
  wire tx_full = tx_cnt_ff == CNT_FULL;
  wire [31:0] fifo_status_word = {23'h0, rx_err_any, tx_full, rx_full,
    tx_cnt_ff[2:0], rx_cnt_ff[2:0]};
  // Empty flag is low whenever a byte waits to be sent.
  wire tx_empty = tx_cnt_ff == 4'h0;
  wire rx_ready_data = rx_cnt_ff != 4'h0;
  wire [31:0] line_status_word = {25'h0, tx_empty, rx_ready_data, 5'h00};

  // Read data selection; received data keep the oldest byte in bits 7:0.
  wire [31:0] rd_mux = r_ctl ? {24'h0, fifo_control_ff} :
    r_lctl ? {24'h0, line_control_ff} :
    r_st ? fifo_status_word :
    r_ls ? line_status_word :
    r_rxb ? {24'h0, rx_mem_ff[0].data} :
    r_rxh ? {16'h0, rx_mem_ff[1].data, rx_mem_ff[0].data} :
    r_rxw ? {rx_mem_ff[3].data, rx_mem_ff[2].data, rx_mem_ff[1].data,
      rx_mem_ff[0].data} : 32'h0;

  // ****************************************************************
  // Next state of the bus handshakes
  // ****************************************************************

  wire nxt_aw_hold = (aw_hold_ff | aw_take) & ~wr_do;
  wire nxt_w_hold = (w_hold_ff | w_take) & ~wr_do;
  wire nxt_bvalid = wr_do | (bvalid_ff & ~bready);
  wire nxt_rvalid = ar_take | (rvalid_ff & ~rready);

  // ****************************************************************
  // Write channel registers
  // ****************************************************************

  // Park address and data; ready stays low until the response is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0;
      wlane0_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
      wready_ff <= ~nxt_w_hold & ~nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (aw_take) begin
        awaddr_ff <= awaddr;
      end
      if (w_take) begin
        wdata_ff <= wdata;
        wlane0_ff <= wstrb[0];
      end
      // Unmapped addresses answer with a slave error.
      if (wr_do) begin
        bresp_ff <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // Read channel registers
  // ****************************************************************

  // Data are captured at the address transfer; reads of receive data ports pop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= RESP_OKAY;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_take) begin
        rdata_ff <= rd_mux;
        rresp_ff <= r_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************

  // Software writes land here; the reserved bit always stays zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_control_ff <= FIFO_CONTROL_RST;
      line_control_ff <= LINE_CONTROL_RST;
    end else begin
      if (wr_en & w_ctl) begin
        fifo_control_ff <= {wdata_ff[7:4], 1'b0, wdata_ff[2:0]};
      end
      if (wr_en & w_lctl) begin
        line_control_ff <= {wdata_ff[LC_RX_TO_EN], 7'h00};
      end
    end
  end

  // ****************************************************************
  // Queue storage
  // ****************************************************************

  // Transmit bytes reset to zero; received bytes carry no reset value.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_cnt_ff <= 4'h0;
      rx_cnt_ff <= 4'h0;
      for (int i = 0; i < DEPTH; i++) begin
        tx_mem_ff[i] <= 8'h00;
      end
    end else begin
      tx_cnt_ff <= nxt_tx_cnt;
      rx_cnt_ff <= nxt_rx_cnt;
      tx_mem_ff <= nxt_tx_mem;
    end
  end

  // Receive entries load without reset.
  always_ff @(posedge aclk) begin
    rx_mem_ff <= nxt_rx_mem;
  end

  // ****************************************************************
  // Line side and request outputs
  // ****************************************************************

  // Queue outputs follow the next count so they agree with the queue; the time-out enable follows the control words.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_valid_ff <= 1'b0;
      rx_ready_ff <= 1'b0;
      rx_fifo_req_ff <= 1'b0;
      tx_fifo_req_ff <= 1'b0;
      rx_to_en_ff <= 1'b0;
    end else begin
      tx_valid_ff <= nxt_tx_cnt != 4'h0;
      rx_ready_ff <= (nxt_rx_cnt < rx_cap) & ~fifo_control_ff.rx_queue_flush;
      rx_fifo_req_ff <= fifo_on & (nxt_rx_cnt >= rx_lvl);
      tx_fifo_req_ff <= fifo_on & (nxt_tx_cnt <= tx_lvl);
      rx_to_en_ff <= line_control_ff[LC_RX_TO_EN] & fifo_on;
    end
  end

  // Port drive straight from flip-flops.
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign tx_valid = tx_valid_ff;
  assign tx_byte = tx_mem_ff[0];
  assign rx_ready = rx_ready_ff;
  assign rx_fifo_req = rx_fifo_req_ff;
  assign tx_fifo_req = tx_fifo_req_ff;
  assign rx_timeout_irq_enable = rx_to_en_ff;

endmodule // ufd_top

// [ufd_pkg.sv]
// Constants, types and register map of the UART FIFO data port.
// Overview of operation
// - Control bit 0 picks FIFO or single register.
// - Control bit 1 flushes the receive queue.
// - Control bit 2 flushes transmit queue; bit 3 reserved.
// - Bits 5:4 pick receive level 2/4/6/8.
// - Bits 7:6 pick transmit level 0/2/4/6.
// - Status bits 2:0 show receive count.
// - Status bits 5:3 show transmit count.
// - Status bit 6 flags receive queue full.
// - Status bit 7 flags transmit queue full.
// - Status bit 8 flags an invalid received byte.
// - Holding write clears the transmit empty flag.
// - Byte transmit alias pushes one byte.
// - Half-word transmit alias pushes two bytes.
// - Word transmit alias pushes four bytes.
// - Holding register and byte alias share offset.
// - Receive data at byte, half-word, word aliases.
// - Transmit empty flag is low while data waits.
// - Receive time-out enable acts only in FIFO mode.
package ufd_pkg;

  // Queue depth and count width (0 to 8 needs four bits).
  localparam int DEPTH = 8;
  localparam int CW = 4;
  localparam logic [CW-1:0] CNT_FULL = 4'h8;
  localparam logic [CW-1:0] CNT_ONE = 4'h1;

  // Bus address width and register indices; byte address is four times the index.
  localparam int AW = 17;
  localparam logic [AW-1:0] IDX_LINE_CONTROL = 17'h05007;
  localparam logic [AW-1:0] IDX_LINE_STATUS = 17'h0500b;
  localparam logic [AW-1:0] IDX_FIFO_CONTROL = 17'h0500f;
  localparam logic [AW-1:0] IDX_FIFO_STATUS = 17'h05012;
  localparam logic [AW-1:0] IDX_TX_WORD = 17'h05014;
  localparam logic [AW-1:0] IDX_TX_HALF = 17'h05016;
  localparam logic [AW-1:0] IDX_TX_BYTE = 17'h05017;
  localparam logic [AW-1:0] IDX_RX_WORD = 17'h05018;
  localparam logic [AW-1:0] IDX_RX_HALF = 17'h0501a;
  localparam logic [AW-1:0] IDX_RX_BYTE = 17'h0501b;

  // Field positions of the status words and the line control word.
  localparam int ST_TX_CNT = 3;
  localparam int ST_RX_FULL = 6;
  localparam int ST_TX_FULL = 7;
  localparam int ST_RX_ERR = 8;
  localparam int LS_RX_READY = 5;
  localparam int LS_TX_EMPTY = 6;
  localparam int LC_RX_TO_EN = 7;

  // Reset values and bus answers.
  localparam logic [7:0] FIFO_CONTROL_RST = 8'h00;
  localparam logic [7:0] LINE_CONTROL_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Trigger level tables, four bits per code, code 0 in the low nibble.
  localparam logic [15:0] RX_TRIG_LVL = 16'h8642;
  localparam logic [15:0] TX_TRIG_LVL = 16'h6420;

  // Bytes moved by byte, half-word and word accesses.
  localparam logic [CW-1:0] N_BYTE = 4'h1;
  localparam logic [CW-1:0] N_HALF = 4'h2;
  localparam logic [CW-1:0] N_WORD = 4'h4;

  // One received byte with its invalid mark.
  typedef struct packed {
    logic err;
    logic [7:0] data;
  } ufd_rx_entry_t;

  // Layout of the FIFO control register.
  typedef struct packed {
    logic [1:0] tx_trigger_level;
    logic [1:0] rx_trigger_level;
    logic rsvd;
    logic tx_queue_flush;
    logic rx_queue_flush;
    logic fifo_mode_select;
  } ufd_fifo_ctrl_t;

endpackage

// [ufd_props.sv]
// Port-level concurrent checks for the UART FIFO data port.
`timescale 1ns/1ps
module ufd_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic rx_ready,
  input wire logic rx_fifo_req,
  input wire logic tx_fifo_req
);
  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves are taken at one edge.
  sequence both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  // One parked cycle, then the answer.
  sequence answer_late;
    ##2 bvalid;
  endsequence
  AST_RST_QUIET: assert property (
    disable iff (1'b0) !aresetn |=> !(bvalid || rvalid || tx_valid || rx_ready || rx_fifo_req
    || tx_fifo_req || awready || arready)) else $error("output active after reset edge");
  AST_WR_LAT: assert property (both_taken |-> answer_late)
    else $error("write answer not two cycles after request");
  AST_RD_LAT: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  AST_W_REFUSE: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  AST_B_DONE: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("response not retired");
  AST_TX_HOLD: assert property (
    tx_valid && !tx_ready |=> bvalid || (tx_valid && $stable(tx_byte)))
    else $error("head byte lost while line stalls");
  AST_AR_REFUSE: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
endmodule // ufd_props
bind ufd_top ufd_props ufd_props_inst (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .tx_valid, .tx_byte,
  .tx_ready, .rx_ready, .rx_fifo_req, .tx_fifo_req);

// [ufd_line_model.sv]
// Behavioural model of the remote serial transceiver on the line side.
`timescale 1ns/1ps
module ufd_line_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready,
  output logic rx_valid,
  output ufd_pkg::ufd_rx_entry_t rx_entry,
  input wire logic rx_ready
);
  import ufd_pkg::*;
  // ****************
  // Line model
  // ****************
  logic [7:0] got_q[$]; // Bytes taken from the transmit side, oldest first.
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_entry = '0;
  end
  // Takes a byte whenever not stalled; stall models a slow line.
  always @(posedge aclk) begin
    tx_ready <= aresetn && !stall;
    if (tx_valid && tx_ready) begin
      got_q.push_back(tx_byte);
    end
  end
  // Offers one byte and holds it until taken, then scrambles the released line.
  task automatic send(input logic [7:0] d, input logic e);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_entry <= {e, d};
    do @(posedge aclk); while (!rx_ready);
    rx_valid <= 1'b0;
    rx_entry <= {!e, ~d};
  endtask
endmodule // ufd_line_model

// [tb.sv]
// Self-checking bench for the UART FIFO data port.
`timescale 1ns/1ps
module tb;
  import ufd_pkg::*;
  // ****************
  // Signals and tasks
  // ****************
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, stall = 1'b0;
  logic [AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd_q;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready, rx_valid, rx_ready;
  logic rx_fifo_req, tx_fifo_req, rx_timeout_irq_enable;
  logic [7:0] tx_byte, b;
  ufd_rx_entry_t rx_entry;
  int error_cnt = 0;
  int checks_done = 0;
  // Control value written, value read back, transmit request expected.
  typedef struct packed { logic [7:0] ctrl; logic [7:0] back; logic txreq; } ufd_row_t;
  ufd_row_t rows[4] = '{'{8'h01, 8'h01, 1'b1}, '{8'h08, 8'h00, 1'b0},
    '{8'hc9, 8'hc1, 1'b1}, '{8'h36, 8'h36, 1'b0}};
  always #5 aclk = ~aclk;
  ufd_top ufd_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_entry(rx_entry), .rx_ready(rx_ready), .rx_fifo_req(rx_fifo_req),
    .tx_fifo_req(tx_fifo_req), .rx_timeout_irq_enable(rx_timeout_irq_enable));
  ufd_line_model ufd_line_model_inst (.aclk(aclk), .aresetn(aresetn), .stall(stall),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_entry(rx_entry), .rx_ready(rx_ready));
  // Compares and counts; an unknown matches only an unknown.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Bus write: address and data offered together, each dropped when taken.
  task automatic wr(input logic [AW-1:0] idx, input logic [31:0] d, input logic [1:0] er);
    awaddr <= {idx[AW-3:0], 2'b00};
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    // Response ready follows the response, so the slave must hold it for a cycle.
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    chk(bresp, er);
    @(posedge aclk);
  endtask
  // Bus read; the data land in rd_q.
  task automatic rd(input logic [AW-1:0] idx, input logic [1:0] er);
    araddr <= {idx[AW-3:0], 2'b00};
    arvalid <= 1'b1;
    // Data ready follows the data, so the slave must hold it for a cycle.
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    rd_q = rdata;
    chk(rresp, er);
  endtask
  // Reads the FIFO status word and compares its nine defined bits.
  task automatic st(input logic [8:0] e);
    rd(IDX_FIFO_STATUS, RESP_OKAY);
    chk(rd_q[8:0], e);
  endtask
  task automatic drain();
    for (int n = 0; n < 100 && tx_valid; n++) @(posedge aclk);
  endtask
  // Cuts a hung run short.
  initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    end_of_test();
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_FIFO_CONTROL, RESP_OKAY);
    chk(rd_q[7:0], FIFO_CONTROL_RST);
    st(9'h000);
    foreach (rows[i]) begin
      wr(IDX_FIFO_CONTROL, {24'h0, rows[i].ctrl}, RESP_OKAY);
      rd(IDX_FIFO_CONTROL, RESP_OKAY);
      chk(rd_q[7:0], rows[i].back);
      chk(tx_fifo_req, rows[i].txreq);
    end
    wr(IDX_LINE_CONTROL, 32'h80, RESP_OKAY);
    chk(rx_timeout_irq_enable, 1'b0);
    wr(IDX_FIFO_CONTROL, 32'hc1, RESP_OKAY);
    chk(rx_timeout_irq_enable, 1'b1);
    // Transmit queue filled past full while the line stalls.
    stall <= 1'b1;
    wr(IDX_TX_WORD, 32'h44332211, RESP_OKAY);
    st(9'h020);
    wr(IDX_TX_HALF, 32'h00006655, RESP_OKAY);
    st(9'h030);
    wr(IDX_TX_BYTE, 32'h77, RESP_OKAY);
    st(9'h038);
    chk(tx_fifo_req, 1'b0);
    wr(IDX_TX_BYTE, 32'h88, RESP_OKAY);
    wr(IDX_TX_BYTE, 32'h99, RESP_OKAY);
    st(9'h080);
    rd(IDX_LINE_STATUS, RESP_OKAY);
    chk(rd_q[LS_TX_EMPTY], 1'b0);
    stall <= 1'b0;
    drain();
    chk(ufd_line_model_inst.got_q.size(), 8);
    for (int i = 0; i < 8; i++) chk(ufd_line_model_inst.got_q[i], 8'h11 * (i + 1));
    chk(tx_fifo_req, 1'b1);
    // Flush of a loaded transmit queue.
    stall <= 1'b1;
    wr(IDX_TX_WORD, 32'h0, RESP_OKAY);
    wr(IDX_FIFO_CONTROL, 32'h05, RESP_OKAY);
    st(9'h000);
    chk(tx_valid, 1'b0);
    // Receive queue filled at every trigger level, then read by each alias down to one byte.
    for (int c = 0; c < 4; c++) begin
      b = {c[3:0], 4'h0};
      wr(IDX_FIFO_CONTROL, {26'h0, c[1:0], 4'h3}, RESP_OKAY);
      wr(IDX_FIFO_CONTROL, {26'h0, c[1:0], 4'h1}, RESP_OKAY);
      for (int k = 1; k <= 8; k++) begin
        ufd_line_model_inst.send(b + k[7:0], k == 1);
        @(posedge aclk);
        chk(rx_fifo_req, k >= 2 * c + 2);
      end
      st(9'h140);
      chk(rx_ready, 1'b0);
      rd(IDX_RX_WORD, RESP_OKAY);
      chk(rd_q, {b + 8'h4, b + 8'h3, b + 8'h2, b + 8'h1});
      rd(IDX_RX_HALF, RESP_OKAY);
      chk(rd_q[15:0], {b + 8'h6, b + 8'h5});
      rd(IDX_RX_BYTE, RESP_OKAY);
      chk(rd_q[7:0], b + 8'h7);
      st(9'h001);
    end
    // Single holding register mode.
    wr(IDX_FIFO_CONTROL, 32'h02, RESP_OKAY);
    wr(IDX_FIFO_CONTROL, 32'h00, RESP_OKAY);
    rd(IDX_LINE_STATUS, RESP_OKAY);
    chk(rd_q[LS_TX_EMPTY], 1'b1);
    wr(IDX_TX_BYTE, 32'ha5, RESP_OKAY);
    wr(IDX_TX_HALF, 32'hbbbb, RESP_OKAY);
    rd(IDX_LINE_STATUS, RESP_OKAY);
    chk(rd_q[LS_TX_EMPTY], 1'b0);
    chk(tx_byte, 8'ha5);
    chk(tx_fifo_req, 1'b0);
    stall <= 1'b0;
    drain();
    chk(ufd_line_model_inst.got_q.size(), 9);
    chk(ufd_line_model_inst.got_q[8], 8'ha5);
    // Unmapped place, read-only word and transmit port reads.
    wr(17'h01000, 32'h1, RESP_SLVERR);
    rd(17'h01000, RESP_SLVERR);
    wr(IDX_FIFO_STATUS, 32'h1ff, RESP_OKAY);
    st(9'h000);
    rd(IDX_TX_WORD, RESP_OKAY);
    chk(rd_q, 32'h0);
    // Reset in mid-run with a byte waiting on a stalled line.
    stall <= 1'b1;
    wr(IDX_FIFO_CONTROL, 32'h01, RESP_OKAY);
    wr(IDX_TX_BYTE, 32'h5a, RESP_OKAY);
    chk(tx_valid, 1'b1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk(tx_valid, 1'b0);
    rd(IDX_FIFO_CONTROL, RESP_OKAY);
    chk(rd_q[7:0], FIFO_CONTROL_RST);
    st(9'h000);
    end_of_test();
  end
endmodule // tb
